/* cets_consts.svh */
// Constant definitions for the execution state timing block.
`ifndef CETS_CONSTS_SVH
`define CETS_CONSTS_SVH
`define CETS_FETCH_STATES_MEM 4'h2
`define CETS_BRANCH_STATES_MEM 4'h2
`define CETS_STACK_STATES_MEM 4'h2
`define CETS_DATA_STATES_MEM 4'h2
`define CETS_DATA_STATES_PERIPH_FAST 4'h2
`define CETS_DATA_STATES_PERIPH_SLOW 4'h3
`define CETS_INTERNAL_STATES 4'h1
`define CETS_CNT_ZERO 4'h0
`define CETS_CNT_ONE 4'h1
`define CETS_CNT_TWO 4'h2
`define CETS_CNT_THREE 4'h3
`define CETS_TOTAL_ZERO 8'h00
`define CETS_NUM_KINDS 6
`define CETS_KIND_FETCH 3'h0
`define CETS_KIND_BRANCH 3'h1
`define CETS_KIND_STACK 3'h2
`define CETS_KIND_BYTE 3'h3
`define CETS_KIND_WORD 3'h4
`define CETS_KIND_INTERNAL 3'h5
`endif

/* cets_mem_model.sv */
// Access location model of the on-chip memory and peripheral modules.
`timescale 1ns/1ps
module cets_mem_model
    import cets_pkg::*;
(
    input wire logic [1:0] sel_i,
    output cets_loc_s loc_o
);
    // Select 0 is memory, 1 a two-state peripheral, 2 a three-state peripheral.
    assign loc_o = '{fetch_periph: 1'b0, data_periph: sel_i != 2'h0, periph_slow: sel_i == 2'h2};
endmodule : cets_mem_model

/* cets_pkg.sv */
// Types shared by the execution state timing block.
package cets_pkg;
    typedef enum logic [4:0] {
        CETS_OP_ADD_REG = 5'h00,
        CETS_OP_ADD_IMM8 = 5'h01,
        CETS_OP_ADD_IMM16 = 5'h02,
        CETS_OP_ADD_IMM32 = 5'h03,
        CETS_OP_QUICK_ADD = 5'h04,
        CETS_OP_ADD_WITH_CARRY = 5'h05,
        CETS_OP_AND_BYTE = 5'h06,
        CETS_OP_AND_WORD_REG = 5'h07,
        CETS_OP_AND_IMM16 = 5'h08,
        CETS_OP_AND_IMM32 = 5'h09,
        CETS_OP_AND_LONG_REG = 5'h0A,
        CETS_OP_AND_COND_REG = 5'h0B,
        CETS_OP_BIT_AND_REG = 5'h0C,
        CETS_OP_BIT_AND_MEM = 5'h0D,
        CETS_OP_BRANCH_D8 = 5'h0E,
        CETS_OP_BRANCH_D16 = 5'h0F
    } cets_op_e;

    typedef enum logic [2:0] {
        CETS_IDLE = 3'h1,
        CETS_BUSY = 3'h2,
        CETS_DONE = 3'h4
    } cets_state_e;

    // Cycle counts of each kind for one instruction.
    typedef struct packed {
        logic [3:0] fetch;
        logic [3:0] branch_read;
        logic [3:0] stack;
        logic [3:0] byte_access;
        logic [3:0] word_access;
        logic [3:0] internal;
    } cets_cycles_s;

    // Access location of fetch and data access cycles.
    typedef struct packed {
        logic fetch_periph;
        logic data_periph;
        logic periph_slow;
    } cets_loc_s;
endpackage : cets_pkg

/* cets_timing.sv */
// Execution state timing calculator for the CPU instruction groups.
`timescale 1ns/1ps
`include "cets_consts.svh"

// Operation
// RL1 - Total states are the sum of each cycle count times its state cost.
// RL2 - A fetch cycle from on-chip memory costs two states.
// RL3 - A data access to an on-chip peripheral costs two or three states.
// RL4 - An internal operation cycle costs one state wherever it occurs.
// RL5 - Register quick_add_op, byte quick_add_op, quick add, carry add, byte AND: one fetch.
// RL6 - Add or AND with 16-bit immediate uses two fetch cycles only.
// RL7 - Add or AND with 32-bit immediate uses three fetch cycles only.
// RL8 - Long register to long register AND uses two fetch cycles.
// RL9 - Bit AND: register one fetch; memory two fetches plus one byte access.
// RL10 - Branch with 8-bit displacement uses two fetches, taken or not.
// RL11 - Branch with 16-bit displacement uses two fetches and two internals.
// RL12 - A blank cycle count counts as zero cycles.
module cets_timing
    import cets_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic req_i,
    input wire cets_op_e op_i,
    input wire cets_loc_s loc_i,
    output logic ready_o,
    output logic done_o,
    output cets_cycles_s cycles_o,
    output logic [7:0] states_o
);

    // Evaluation state and the request captured when it is taken.
    cets_state_e state;
    cets_cycles_s table_cycles;
    cets_cycles_s cur_cycles;
    cets_loc_s cur_loc;
    logic [3:0] s_fetch;
    logic [3:0] s_data;
    logic [7:0] next_states;
    logic take;

    // Per-kind views of the captured counts and of their state costs.
    logic [3:0] kind_count [`CETS_NUM_KINDS];
    logic [3:0] kind_cost [`CETS_NUM_KINDS];
    logic [7:0] kind_states [`CETS_NUM_KINDS];

    // ------------------------------------------------------------
    // Cycle count table
    // ------------------------------------------------------------
    always_comb begin
        // Codes outside every group keep zero counts of every kind.
        table_cycles = '{default: `CETS_CNT_ZERO}; // see RL12
        case (op_i)
            CETS_OP_ADD_REG,
            CETS_OP_ADD_IMM8,
            CETS_OP_QUICK_ADD,
            CETS_OP_ADD_WITH_CARRY,
            CETS_OP_AND_BYTE,
            CETS_OP_AND_WORD_REG,
            CETS_OP_AND_COND_REG: begin
                table_cycles.fetch = `CETS_CNT_ONE; // see RL5
            end
            CETS_OP_ADD_IMM16,
            CETS_OP_AND_IMM16: begin
                table_cycles.fetch = `CETS_CNT_TWO; // see RL6
            end
            CETS_OP_ADD_IMM32,
            CETS_OP_AND_IMM32: begin
                table_cycles.fetch = `CETS_CNT_THREE; // see RL7
            end
            CETS_OP_AND_LONG_REG: begin
                table_cycles.fetch = `CETS_CNT_TWO; // see RL8
            end
            CETS_OP_BIT_AND_REG: begin
                table_cycles.fetch = `CETS_CNT_ONE; // see RL9
            end
            CETS_OP_BIT_AND_MEM: begin
                table_cycles.fetch = `CETS_CNT_TWO; // see RL9
                table_cycles.byte_access = `CETS_CNT_ONE; // see RL9
            end
            CETS_OP_BRANCH_D8: begin
                table_cycles.fetch = `CETS_CNT_TWO; // see RL10
            end
            CETS_OP_BRANCH_D16: begin
                table_cycles.fetch = `CETS_CNT_TWO; // see RL11
                table_cycles.internal = `CETS_CNT_TWO; // see RL11
            end
            default: begin
                table_cycles = '{default: `CETS_CNT_ZERO};
            end
        endcase
    end

    // ------------------------------------------------------------
    // Per-cycle state costs
    // ------------------------------------------------------------
    // Peripheral fetches are not modelled; such a fetch is charged the memory cost.
    // Byte and word accesses share one cost, picked by the captured location.
    always_comb begin
        s_fetch = `CETS_FETCH_STATES_MEM; // see RL2
        if (cur_loc.data_periph) begin
            s_data = cur_loc.periph_slow ? `CETS_DATA_STATES_PERIPH_SLOW
                                         : `CETS_DATA_STATES_PERIPH_FAST; // see RL3
        end else begin
            s_data = `CETS_DATA_STATES_MEM;
        end
    end

    // Branch address reads and stack operations always go to on-chip memory.
    always_comb begin
        kind_cost[`CETS_KIND_FETCH] = s_fetch; // see RL2
        kind_cost[`CETS_KIND_BRANCH] = `CETS_BRANCH_STATES_MEM;
        kind_cost[`CETS_KIND_STACK] = `CETS_STACK_STATES_MEM;
        kind_cost[`CETS_KIND_BYTE] = s_data; // see RL3
        kind_cost[`CETS_KIND_WORD] = s_data; // see RL3
        kind_cost[`CETS_KIND_INTERNAL] = `CETS_INTERNAL_STATES; // see RL4
    end

    // ------------------------------------------------------------
    // Per-kind cycle counts
    // ------------------------------------------------------------
    // The struct fields are laid out as an array, so one loop covers every kind.
    // The index of each kind follows the field order of the cycle count struct.
    always_comb begin
        kind_count[`CETS_KIND_FETCH] = cur_cycles.fetch;
        kind_count[`CETS_KIND_BRANCH] = cur_cycles.branch_read;
        kind_count[`CETS_KIND_STACK] = cur_cycles.stack;
        kind_count[`CETS_KIND_BYTE] = cur_cycles.byte_access;
        kind_count[`CETS_KIND_WORD] = cur_cycles.word_access;
        kind_count[`CETS_KIND_INTERNAL] = cur_cycles.internal;
    end

    // ------------------------------------------------------------
    // Execution state total
    // ------------------------------------------------------------
    // Both factors are widened to the total's width first, so that a product
    // never wraps inside four bits before it is added up.
    generate
        for (genvar g = 0; g < `CETS_NUM_KINDS; g++) begin : g_kind
            assign kind_states[g] = {4'h0, kind_count[g]} * {4'h0, kind_cost[g]}; // see RL1
        end
    endgenerate

    // Eight bits hold the largest total that any instruction group produces.
    // A kind with no cycles quick_add_op nothing to the total.
    always_comb begin
        next_states = `CETS_TOTAL_ZERO;
        for (int k = 0; k < `CETS_NUM_KINDS; k++) begin
            next_states = next_states + kind_states[k]; // see RL1 RL12
        end
    end

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    // Each evaluation passes busy and done before the block is idle again,
    // so a request can be taken at most every third edge.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state <= CETS_IDLE;
        end else begin
            case (state)
                CETS_IDLE: begin
                    if (take) begin
                        state <= CETS_BUSY;
                    end
                end
                CETS_BUSY: begin
                    state <= CETS_DONE;
                end
                CETS_DONE: begin
                    state <= CETS_IDLE;
                end
                default: begin
                    state <= CETS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Request acceptance
    // ------------------------------------------------------------
    // A request is taken only while idle; one raised at any other time must be held until then.
    // Ready is combinational, so a waiting request is taken on the first idle edge.
    assign take = (state == CETS_IDLE) && req_i;
    assign ready_o = (state == CETS_IDLE);

    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    // The counts and the access location are held for the whole evaluation,
    // so that the inputs may change as soon as the request is taken.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cur_cycles <= '{default: `CETS_CNT_ZERO};
            cur_loc <= '0;
        end else if (take) begin
            cur_cycles <= table_cycles;
            cur_loc <= loc_i;
        end
    end

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    // The done pulse lasts one cycle and marks the cycle in which new results
    // first stand on the outputs.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (state == CETS_BUSY);
        end
    end

    // Counts and total are loaded once per evaluation and then left alone.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cycles_o <= '{default: `CETS_CNT_ZERO};
            states_o <= `CETS_TOTAL_ZERO;
        end else if (state == CETS_BUSY) begin
            cycles_o <= cur_cycles;
            states_o <= next_states;
        end
    end

endmodule : cets_timing

/* cets_timing_sva.sv */
// Assertion checker for the execution state timing block.
`timescale 1ns/1ps
module cets_timing_sva
    import cets_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic req_i,
    input wire cets_op_e op_i,
    input wire cets_loc_s loc_i,
    input wire logic ready_o,
    input wire logic done_o,
    input wire cets_cycles_s cycles_o,
    input wire logic [7:0] states_o
);
    cets_op_e op1;
    cets_op_e op2;
    logic slow1;
    logic slow2;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // The operation and data cost of the request are carried to the cycle of its answer.
    always_ff @(posedge sys_clk_i) begin
        op1 <= op_i;
        op2 <= op1;
        slow1 <= loc_i.data_periph && loc_i.periph_slow;
        slow2 <= slow1;
    end
    property p_answer; req_i && ready_o |=> !ready_o ##1 done_o; endproperty
    a_answer: assert property (p_answer) else $error("answer late");
    property p_pulse; done_o |=> !done_o; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_total; done_o |-> states_o == 8'(cycles_o.fetch * 2 + cycles_o.branch_read * 2
        + cycles_o.stack * 2 + (cycles_o.byte_access + cycles_o.word_access) * (slow2 ? 3 : 2)
        + cycles_o.internal); endproperty
    a_total: assert property (p_total) else $error("bad total");
    property p_one; done_o && op2 inside {CETS_OP_ADD_REG, CETS_OP_ADD_IMM8, CETS_OP_QUICK_ADD,
        CETS_OP_ADD_WITH_CARRY, CETS_OP_AND_BYTE, CETS_OP_AND_WORD_REG, CETS_OP_AND_COND_REG,
        CETS_OP_BIT_AND_REG} |-> cycles_o == 24'h100000; endproperty
    a_one: assert property (p_one) else $error("bad single fetch");
    property p_two; done_o && op2 inside {CETS_OP_ADD_IMM16, CETS_OP_AND_IMM16, CETS_OP_AND_LONG_REG,
        CETS_OP_BRANCH_D8} |-> cycles_o == 24'h200000; endproperty
    a_two: assert property (p_two) else $error("bad two fetch");
    property p_three; done_o && op2 inside {CETS_OP_ADD_IMM32, CETS_OP_AND_IMM32}
        |-> cycles_o == 24'h300000; endproperty
    a_three: assert property (p_three) else $error("bad three fetch");
    property p_bitmem; done_o && op2 == CETS_OP_BIT_AND_MEM |-> cycles_o == 24'h200100; endproperty
    a_bitmem: assert property (p_bitmem) else $error("bad bit memory");
    property p_d16; done_o && op2 == CETS_OP_BRANCH_D16 |-> cycles_o == 24'h200002; endproperty
    a_d16: assert property (p_d16) else $error("bad long branch");
endmodule : cets_timing_sva

/* cets_timing_tb_top.sv */
// Self-checking testbench of the execution state timing block.
`timescale 1ns/1ps
module cets_timing_tb_top;
    import cets_pkg::*;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic req_i = 1'b0;
    logic ready_o;
    logic done_o;
    logic [1:0] sel = 2'h0;
    cets_op_e op_i = CETS_OP_ADD_REG;
    cets_loc_s loc_i;
    cets_cycles_s cycles_o;
    logic [7:0] states_o;
    int mismatches = 0;
    int n_tests = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    cets_mem_model i_mem (.sel_i(sel), .loc_o(loc_i));
    cets_timing i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_i(req_i), .op_i(op_i), .loc_i(loc_i),
        .ready_o(ready_o), .done_o(done_o), .cycles_o(cycles_o), .states_o(states_o));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run(input cets_op_e op, input logic [1:0] s, input logic [23:0] cyc, input logic [7:0] st);
        int n;
        check({23'h0, ready_o}, 24'h000001);
        op_i = op;
        sel = s;
        req_i = 1'b1;
        @(posedge sys_clk_i) #1 req_i = 1'b0;
        check({23'h0, ready_o}, 24'h000000);
        n = 0;
        while (done_o !== 1'b1 && n < 8) begin
            @(posedge sys_clk_i) #1 n++;
        end
        check({23'h0, done_o}, 24'h000001);
        check(24'(n), 24'h000001);
        check(cycles_o, cyc);
        check({16'h0000, states_o}, {16'h0000, st});
        @(posedge sys_clk_i) #1;
        check({22'h0, ready_o, done_o}, 24'h000002);
        check({16'h0000, states_o}, {16'h0000, st});
    endtask : run
    task automatic t_one_fetch;
        cets_op_e ops[8] = '{CETS_OP_ADD_REG, CETS_OP_ADD_IMM8, CETS_OP_QUICK_ADD, CETS_OP_ADD_WITH_CARRY,
            CETS_OP_AND_BYTE, CETS_OP_AND_WORD_REG, CETS_OP_AND_COND_REG, CETS_OP_BIT_AND_REG};
        foreach (ops[i]) run(ops[i], 2'h2, 24'h100000, 8'h02);
    endtask : t_one_fetch
    task automatic t_multi_fetch;
        run(CETS_OP_ADD_IMM16, 2'h0, 24'h200000, 8'h04);
        run(CETS_OP_AND_IMM16, 2'h1, 24'h200000, 8'h04);
        run(CETS_OP_ADD_IMM32, 2'h0, 24'h300000, 8'h06);
        run(CETS_OP_AND_IMM32, 2'h2, 24'h300000, 8'h06);
        run(CETS_OP_AND_LONG_REG, 2'h0, 24'h200000, 8'h04);
    endtask : t_multi_fetch
    task automatic t_bit_mem;
        run(CETS_OP_BIT_AND_MEM, 2'h0, 24'h200100, 8'h06);
        run(CETS_OP_BIT_AND_MEM, 2'h1, 24'h200100, 8'h06);
        run(CETS_OP_BIT_AND_MEM, 2'h2, 24'h200100, 8'h07);
    endtask : t_bit_mem
    task automatic t_branch;
        run(CETS_OP_BRANCH_D8, 2'h2, 24'h200000, 8'h04);
        run(CETS_OP_BRANCH_D16, 2'h2, 24'h200002, 8'h06);
    endtask : t_branch
    task automatic t_reset;
        op_i = CETS_OP_BIT_AND_MEM;
        sel = 2'h2;
        req_i = 1'b1;
        @(posedge sys_clk_i) #1 req_i = 1'b0;
        srst_i = 1'b1;
        @(posedge sys_clk_i) #1;
        check({22'h0, ready_o, done_o}, 24'h000002);
        check(cycles_o, 24'h000000);
        check({16'h0000, states_o}, 24'h000000);
        srst_i = 1'b0;
        run(CETS_OP_BRANCH_D16, 2'h0, 24'h200002, 8'h06);
    endtask : t_reset
    task automatic tally_and_finish;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #40000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        #1 srst_i = 1'b0;
        t_one_fetch();
        t_multi_fetch();
        t_bit_mem();
        t_branch();
        t_reset();
        tally_and_finish();
    end
endmodule : cets_timing_tb_top
bind cets_timing cets_timing_sva i_sva (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_i(req_i), .op_i(op_i),
    .loc_i(loc_i), .ready_o(ready_o), .done_o(done_o), .cycles_o(cycles_o), .states_o(states_o));
